// ---- rtl/rtcss_params.svh ----
// Constants of the three-line serial slave: command fields, codes and reset values.
`ifndef RTCSS_PARAMS_SVH
`define RTCSS_PARAMS_SVH

`define RTCSS_BYTE_BITS      8
`define RTCSS_ADDR_BITS      4
`define RTCSS_DIR_BIT        7
`define RTCSS_SUB_HI         6
`define RTCSS_SUB_LO         4
`define RTCSS_START_HI       3
`define RTCSS_START_LO       0
`define RTCSS_SUB_CODE       3'h1
`define RTCSS_LAST_REG       4'hf
`define RTCSS_ADDR_RESET     4'h0
`define RTCSS_BYTE_RESET     8'h00
`define RTCSS_BITCNT_RESET   3'h0
`define RTCSS_BITCNT_LAST    3'h7
`define RTCSS_SYNC_STAGES    2

`endif

// ---- rtl/rtcss_pkg.sv ----
// Types shared by the three-line serial slave modules.
package rtcss_pkg;

  typedef logic [7:0] rtcss_byte_t;
  typedef logic [3:0] rtcss_addr_t;

  typedef enum logic [1:0] {
    RTCSS_COMMAND,
    RTCSS_WRITE,
    RTCSS_READ,
    RTCSS_IGNORE
  } rtcss_state_t;

endpackage : rtcss_pkg

// ---- rtl/rtcss_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none

module rtcss_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] firstStage;

  // Each pin gets its own pair of flops; only the second flop is visible outside.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge clk) begin
        if (reset) begin
          firstStage[i] <= 1'b0;
          syncOut[i]    <= 1'b0;
        end else begin
          firstStage[i] <= asyncIn[i];
          syncOut[i]    <= firstStage[i];
        end
      end
    end
  endgenerate

endmodule : rtcss_sync

`default_nettype wire

// ---- rtl/rtcss_byte_shift.sv ----
// Parallel-load, MSB-first output shift register.
`timescale 1ns/1ps
`default_nettype none

module rtcss_byte_shift #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadData,
  input  wire logic             shift,
  output logic                  msb
);

  logic [WIDTH-1:0] shiftReg;
  logic [WIDTH-1:0] next_shiftReg;

  assign next_shiftReg = clear ? '0 :
                         load  ? loadData :
                         shift ? {shiftReg[WIDTH-2:0], 1'b0} : shiftReg;
  assign msb = shiftReg[WIDTH-1];

  always_ff @(posedge clk) begin
    if (reset) begin
      shiftReg <= '0;
    end else begin
      shiftReg <= next_shiftReg;
    end
  end

endmodule : rtcss_byte_shift

`default_nettype wire

// ---- rtl/rtcss_serial_slave.sv ----
// Three-line serial slave port giving a host access to a sixteen-entry register file.
//
// Summary of operation
// [R01] Every byte on the link is eight bits sent most significant bit first in both directions.
// [R02] Chip select is active high and, while low, holds the whole port including bit count and decoding at idle; regAddr and regWriteData keep their last values.
// [R03] The data input is sampled on each rising serial clock edge while chip select is high.
// [R04] The data output changes on each falling serial clock edge so the host samples it on the next rising edge.
// [R05] A sampled bit enters the internal shift logic on the falling edge after the rising edge that caught it.
// [R06] The first byte after chip select rises is a command, and later bytes are write or read data.
// [R07] Command bit 7 selects write (0) or read (1) for every following byte of the selection.
// [R08] Command bits 6 to 4 must read 001, otherwise the rest of the selection is ignored.
// [R09] Command bits 3 to 0 give the first register address, from 0 to f.
// [R10] The register address advances after every data byte and wraps to zero after register f.
// [R11] Data input and output may be tied together into one line without any conflict.
// [R12] While chip select is low, serial clock and data input activity is ignored.
// [R13] The host must drop chip select between transfers so the next byte is decoded as a command.
// [R14] With separate data lines the host must always drive the data input to a defined level.
// [R15] The data output is driven only while read data is being shifted and is released otherwise.
// [R16] A byte cut short by chip select falling is discarded and never written.
`timescale 1ns/1ps
`default_nettype none

`include "rtcss_params.svh"

module rtcss_serial_slave #(
  parameter int SYNC_WIDTH = 3
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                chipSelect,
  input  wire logic                serialClock,
  input  wire logic                serialDataIn,
  output logic                     serialDataOut,
  output logic                     serialDataOutEn,
  output rtcss_pkg::rtcss_addr_t   regAddr,
  output rtcss_pkg::rtcss_byte_t   regWriteData,
  output logic                     regWriteStrobe,
  input  wire rtcss_pkg::rtcss_byte_t regReadData,
  output logic                     regReadStrobe,
  output logic                     transferActive,
  output logic                     transferIgnored
);

  import rtcss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and serial clock edge detection.

  logic [SYNC_WIDTH-1:0] pinSync;
  logic                  csLevel;
  logic                  sckLevel;
  logic                  dataInLevel;
  logic                  sckPrev;
  logic                  sckRise;
  logic                  sckFall;

  rtcss_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({serialDataIn, serialClock, chipSelect}),
    .syncOut (pinSync)
  );

  assign csLevel  = pinSync[0];
  assign sckLevel = pinSync[1];
  assign dataInLevel = pinSync[2];

  // Edges only count while selected, so a floating clock with chip select low does nothing.
  assign sckRise = csLevel & sckLevel & ~sckPrev; // R12
  assign sckFall = csLevel & ~sckLevel & sckPrev; // R12

  always_ff @(posedge clk) begin
    if (reset) begin
      sckPrev <= 1'b0;
    end else begin
      sckPrev <= sckLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Receive path: sample on the rising edge, shift on the following falling edge.

  logic                  sampledBit;
  rtcss_byte_t           rxShift;
  logic [2:0]            bitCount;
  logic                  byteDone;
  rtcss_byte_t           rxByte;

  assign byteDone = sckFall & (bitCount == `RTCSS_BITCNT_LAST);
  assign rxByte   = {rxShift[`RTCSS_BYTE_BITS-2:0], sampledBit}; // R01

  always_ff @(posedge clk) begin
    if (reset || !csLevel) begin
      sampledBit <= 1'b0; // R02
    end else if (sckRise) begin
      sampledBit <= dataInLevel; // R03
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !csLevel) begin
      rxShift  <= `RTCSS_BYTE_RESET; // R02 R16
      bitCount <= `RTCSS_BITCNT_RESET; // R02
    end else if (sckFall) begin
      rxShift  <= rxByte; // R05 R01
      bitCount <= bitCount + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Command decoding.

  function automatic logic rtcss_sub_ok(input rtcss_byte_t cmd);
    rtcss_sub_ok = (cmd[`RTCSS_SUB_HI:`RTCSS_SUB_LO] == `RTCSS_SUB_CODE);
  endfunction : rtcss_sub_ok

  rtcss_state_t          state;
  rtcss_state_t          next_state;
  logic                  cmdDone;
  logic                  cmdAccepted;
  logic                  cmdIsRead;
  rtcss_addr_t           cmdStart;
  logic                  dataDone;
  rtcss_addr_t           next_regAddr;

  assign cmdDone     = byteDone & (state == RTCSS_COMMAND); // R06
  assign cmdAccepted = cmdDone & rtcss_sub_ok(rxByte); // R08
  assign cmdIsRead   = rxByte[`RTCSS_DIR_BIT]; // R07
  assign cmdStart    = rxByte[`RTCSS_START_HI:`RTCSS_START_LO]; // R09
  assign dataDone    = byteDone & ((state == RTCSS_WRITE) | (state == RTCSS_READ));

  always_comb begin
    next_state = state;
    case (state)
      RTCSS_COMMAND: begin
        if (cmdDone) begin
          if (!rtcss_sub_ok(rxByte)) begin
            next_state = RTCSS_IGNORE; // R08
          end else if (cmdIsRead) begin
            next_state = RTCSS_READ; // R07
          end else begin
            next_state = RTCSS_WRITE; // R07
          end
        end
      end
      RTCSS_WRITE:  next_state = RTCSS_WRITE;
      RTCSS_READ:   next_state = RTCSS_READ;
      RTCSS_IGNORE: next_state = RTCSS_IGNORE;
      default:      next_state = RTCSS_COMMAND;
    endcase
  end

  // Only a deselect or a reset brings the port back to command decoding.
  always_ff @(posedge clk) begin
    if (reset || !csLevel) begin
      state <= RTCSS_COMMAND; // R02 R13
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register address counter.

  assign next_regAddr = cmdAccepted ? cmdStart :
                        !dataDone ? regAddr :
                        (regAddr == `RTCSS_LAST_REG) ? `RTCSS_ADDR_RESET : regAddr + 4'h1; // R09 R10

  always_ff @(posedge clk) begin
    if (reset) begin
      regAddr <= `RTCSS_ADDR_RESET;
    end else begin
      regAddr <= next_regAddr; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Write path: a register is written only when all eight bits have arrived.

  always_ff @(posedge clk) begin
    if (reset) begin
      regWriteData   <= `RTCSS_BYTE_RESET;
      regWriteStrobe <= 1'b0;
    end else begin
      regWriteStrobe <= byteDone & (state == RTCSS_WRITE); // R16
      if (byteDone && state == RTCSS_WRITE) begin
        regWriteData <= rxByte; // R06
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read path: fetch after each accepted read command or read byte, then shift out on falling edges.

  logic                  txMsb;
  logic                  txShift;
  logic                  next_readFetch;

  assign next_readFetch = csLevel & ((cmdAccepted & cmdIsRead) | (byteDone & (state == RTCSS_READ)));
  assign txShift        = sckFall & (state == RTCSS_READ); // R04

  // The fetch lands one clock after the falling edge, well inside the serial clock low phase.
  always_ff @(posedge clk) begin
    if (reset || !csLevel) begin
      regReadStrobe <= 1'b0; // R02
    end else begin
      regReadStrobe <= next_readFetch;
    end
  end

  rtcss_byte_shift #(
    .WIDTH (`RTCSS_BYTE_BITS)
  ) u_tx (
    .clk      (clk),
    .reset    (reset),
    .clear    (~csLevel),
    .load     (regReadStrobe),
    .loadData (regReadData),
    .shift    (txShift),
    .msb      (txMsb)
  );

  assign serialDataOut = txMsb; // R04 R01

  // The output is enabled only in read data bytes, keeping a tied line free otherwise.
  always_ff @(posedge clk) begin
    if (reset || !csLevel) begin
      serialDataOutEn <= 1'b0; // R15 R11
    end else begin
      serialDataOutEn <= (state == RTCSS_READ); // R15 R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Status outputs.

  always_ff @(posedge clk) begin
    if (reset) begin
      transferActive  <= 1'b0;
      transferIgnored <= 1'b0;
    end else begin
      transferActive  <= csLevel;
      transferIgnored <= cmdDone & ~rtcss_sub_ok(rxByte); // R08
    end
  end

endmodule : rtcss_serial_slave

`default_nettype wire

// ---- verification/rtcss_checker.sv ----
// Concurrent checks on the serial slave port.
`timescale 1ns/1ps
`default_nettype none
module rtcss_checker (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   chipSelect,
  input wire logic                   serialClock,
  input wire logic                   serialDataOut,
  input wire logic                   serialDataOutEn,
  input wire rtcss_pkg::rtcss_addr_t regAddr,
  input wire logic                   regWriteStrobe,
  input wire logic                   regReadStrobe,
  input wire logic                   transferActive,
  input wire logic                   transferIgnored
);
  import rtcss_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  reset_clears_a: assert property (disable iff (1'b0) reset |=> regAddr == 4'h0 && !serialDataOutEn)
    else $error("state not cleared by reset");
  cs_idle_a: assert property (!chipSelect [*5] |-> !transferActive && !serialDataOutEn && !regWriteStrobe)
    else $error("activity while deselected");
  write_pulse_a: assert property (regWriteStrobe |=> !regWriteStrobe [*8])
    else $error("write strobes too close");
  addr_step_a: assert property (regWriteStrobe |-> regAddr == $past(regAddr) + 4'h1)
    else $error("address did not advance");
  read_drive_a: assert property (regReadStrobe |=> serialDataOutEn)
    else $error("read without output drive");
  no_clash_a: assert property (serialDataOutEn |-> !regWriteStrobe)
    else $error("output driven during write");
  ignore_quiet_a: assert property (transferIgnored |=> (!regWriteStrobe && !regReadStrobe && !serialDataOutEn) [*8])
    else $error("ignored transfer acted");
  out_on_fall_a: assert property ($changed(serialDataOut) |-> !$past(serialClock))
    else $error("output changed outside low clock phase");
  strobe_sel_a: assert property (regWriteStrobe || regReadStrobe |-> transferActive)
    else $error("strobe outside selection");
endmodule : rtcss_checker
bind rtcss_serial_slave rtcss_checker u_rtcss_checker (.clk(clk), .reset(reset), .chipSelect(chipSelect),
  .serialClock(serialClock), .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
  .regAddr(regAddr), .regWriteStrobe(regWriteStrobe), .regReadStrobe(regReadStrobe),
  .transferActive(transferActive), .transferIgnored(transferIgnored));
`default_nettype wire

// ---- verification/rtcss_host_model.sv ----
// Host side of the three-line link: selects, clocks and shifts bytes.
`timescale 1ns/1ps
`default_nettype none
module rtcss_host_model (
  input  wire logic clk,
  input  wire logic serialDataOut,
  output var logic  chipSelect,
  output var logic  serialClock,
  output var logic  serialDataIn
);
  import rtcss_pkg::*;
  initial begin
    chipSelect = 1'b0;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end
  // A deselected data pin keeps toggling so a stale level never passes for data.
  always @(negedge clk) if (!chipSelect) serialDataIn <= ~serialDataIn;
  task automatic frame_start;
    chipSelect = 1'b1;
    repeat (4) @(negedge clk);
  endtask : frame_start
  task automatic frame_end;
    repeat (6) @(negedge clk);
    chipSelect = 1'b0;
    repeat (6) @(negedge clk);
  endtask : frame_end
  task automatic shift(input rtcss_byte_t tx, input int nBits, output rtcss_byte_t rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nBits; i--) begin
      serialDataIn = tx[i];
      repeat (4) @(negedge clk);
      serialClock = 1'b1;
      repeat (4) @(negedge clk);
      rx[i] = serialDataOut;
      serialClock = 1'b0;
    end
  endtask : shift
  task automatic idle_clock(input int n);
    repeat (n) begin
      serialClock = ~serialClock;
      repeat (4) @(negedge clk);
    end
  endtask : idle_clock
endmodule : rtcss_host_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench of the serial slave port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtcss_pkg::*;
  logic        clk, reset, chipSelect, serialClock, serialDataIn, serialDataOut, serialDataOutEn;
  logic        regWriteStrobe, regReadStrobe, transferActive, transferIgnored;
  rtcss_addr_t regAddr, lastAddr;
  rtcss_byte_t regWriteData, regReadData, rx, rx2, w0, r0;
  rtcss_byte_t mem [16];
  logic [7:0]  wrCount = 8'h00, rdCount = 8'h00, ignCount = 8'h00;
  int          n_errors = 0, checked = 0;
  assign regReadData = mem[regAddr];
  rtcss_serial_slave u_rtcss_serial_slave (.clk(clk), .reset(reset), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWriteStrobe(regWriteStrobe), .regReadData(regReadData), .regReadStrobe(regReadStrobe),
    .transferActive(transferActive), .transferIgnored(transferIgnored));
  rtcss_host_model u_rtcss_host_model (.clk(clk), .serialDataOut(serialDataOut), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialDataIn(serialDataIn));
  // The written address is the one held in the cycle before the strobe.
  always @(posedge clk) begin
    lastAddr <= regAddr;
    if (regWriteStrobe) begin
      mem[lastAddr] <= regWriteData;
      wrCount <= wrCount + 8'h01;
    end
    if (regReadStrobe) rdCount <= rdCount + 8'h01;
    if (transferIgnored) ignCount <= ignCount + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic test_write_wrap;
    u_rtcss_host_model.frame_start();
    u_rtcss_host_model.shift(8'h1e, 8, rx);
    check("write oe", {7'h00, serialDataOutEn}, 8'h00);
    u_rtcss_host_model.shift(8'ha5, 8, rx);
    u_rtcss_host_model.shift(8'h3c, 8, rx);
    u_rtcss_host_model.shift(8'h96, 8, rx);
    u_rtcss_host_model.frame_end();
    check("reg e", mem[14], 8'ha5);
    check("reg f", mem[15], 8'h3c);
    check("reg 0", mem[0], 8'h96);
  endtask : test_write_wrap
  task automatic test_read_wrap;
    mem[15] = 8'h5a;
    mem[0] = 8'hc3;
    r0 = rdCount;
    u_rtcss_host_model.frame_start();
    u_rtcss_host_model.shift(8'h9f, 8, rx);
    u_rtcss_host_model.shift(8'h00, 8, rx);
    check("read oe", {7'h00, serialDataOutEn}, 8'h01);
    u_rtcss_host_model.shift(8'h00, 8, rx2);
    u_rtcss_host_model.frame_end();
    check("idle oe", {7'h00, serialDataOutEn}, 8'h00);
    check("fetches", rdCount - r0, 8'h03);
    check("read f", rx, 8'h5a);
    check("read 0", rx2, 8'hc3);
  endtask : test_read_wrap
  task automatic test_bad_sub;
    w0 = wrCount;
    r0 = ignCount;
    for (int s = 0; s < 8; s++) if (s != 1) begin
      u_rtcss_host_model.frame_start();
      u_rtcss_host_model.shift({1'b0, 3'(s), 4'h2}, 8, rx);
      u_rtcss_host_model.shift(8'hff, 8, rx);
      u_rtcss_host_model.frame_end();
    end
    check("ignored", ignCount - r0, 8'h07);
    check("writes", wrCount, w0);
  endtask : test_bad_sub
  task automatic test_partial;
    w0 = wrCount;
    u_rtcss_host_model.frame_start();
    u_rtcss_host_model.shift(8'h13, 8, rx);
    u_rtcss_host_model.shift(8'h77, 5, rx);
    u_rtcss_host_model.frame_end();
    check("writes", wrCount, w0);
    check("addr", {4'h0, regAddr}, 8'h03);
    u_rtcss_host_model.frame_start();
    u_rtcss_host_model.shift(8'h13, 8, rx);
    u_rtcss_host_model.shift(8'h42, 8, rx);
    u_rtcss_host_model.frame_end();
    check("reg 3", mem[3], 8'h42);
  endtask : test_partial
  task automatic test_idle_noise;
    w0 = wrCount;
    r0 = rdCount;
    u_rtcss_host_model.idle_clock(16);
    check("writes", wrCount, w0);
    check("reads", rdCount, r0);
    check("active", {7'h00, transferActive}, 8'h00);
  endtask : test_idle_noise
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400us;
    n_errors++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    for (int i = 0; i < 16; i++) mem[i] = 8'h00;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    test_write_wrap();
    test_read_wrap();
    test_bad_sub();
    test_partial();
    test_idle_noise();
    test_done();
  end
endmodule : testbench
`default_nettype wire
